// [logic/scc_ctrl.sv]
// Control, status and interrupt request logic of a 32-bit symbol counter.
// Assumes clock and oscillator inputs synchronous to mclk_i, one-cycle event
// pulses from the transceiver, and a strobe bus with read data one cycle late.
//
// Summary of operation
// - Resync write clears prescaler and backoff slot counter; the bit self-clears.
// - After resync a full symbol period and full backoff period begin.
// - Resync acts only while the crystal clock is the source in use, enabled or not.
// - Manual capture copies the count to beacon timestamp; bit self-clears.
// - Disabled: counter, backoff and compares stop; count writes are ignored.
// - Select bit one uses the RTC input, zero the crystal input.
// - Transceiver sleep forces the RTC source; wakeup restores the selection.
// - Auto timestamp bit gates frame and beacon capture; manual still works.
// - Relative units match count against beacon plus compare, else compare.
// - Backoff enable starts the slot counter; its request also needs a mask.
// - Backoff flag rises every 20 symbols while running.
// - Wrap flag sets when the count passes all ones to zero.
// - Compare units 1, 2, 3 set flag bits 0, 1, 2.
// - Busy sets on lowest count byte write until the counter is loaded.
// - Masked-in flags request interrupts, clear on service or write one.
// - Masked-out events still set flags but request nothing.
// - All mask bits are zero after reset.
// - Setting a mask over a set flag requests at once.
// - Reserved bits read zero; software writes them as reset value.
// - Mask bits 4 to 0: backoff, wrap, compare 3, 2, 1.
// - Auto mode loads beacon stamp on valid beacon with matching or any PAN.
`timescale 1ns/10ps
`include "scc_map.svh"

module scc_ctrl
	import scc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic crystal_input_i,
	input wire logic rtc_osc_input_i,
	input wire logic trx_sleep_i,
	input wire logic sfd_i,
	input wire logic beacon_valid_i,
	input wire logic [15:0] src_pan_i,
	input wire logic [7:0] pan_identifier_high_i,
	input wire logic [7:0] pan_identifier_low_i,
	input wire logic [4:0] irq_ack_i,
	output logic backoff_irq_o,
	output logic wrap_irq_o,
	output logic match3_irq_o,
	output logic match2_irq_o,
	output logic match1_irq_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Picks byte i out of a word.
	function automatic logic [7:0] get_byte(input scc_word_t v, input logic [1:0] i);
		get_byte = v[{i, 3'h0} +: 8];
	endfunction

	// Replaces byte i of a word.
	function automatic scc_word_t set_byte(input scc_word_t v, input logic [1:0] i,
		input logic [7:0] b);
		scc_word_t r;
		r = v;
		r[{i, 3'h0} +: 8] = b;
		set_byte = r;
	endfunction

	// Tells whether addr falls in the four bytes from base.
	function automatic logic in_grp(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		in_grp = (d < 8'h04);
	endfunction

	// Compare target of one unit in absolute or relative mode.
	function automatic scc_word_t target(input logic rel, input scc_word_t bts,
		input scc_word_t cmp);
		target = rel ? bts + cmp : cmp;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [5:0] ctrl0_reg;
	logic [4:0] ctrl1_reg;
	logic [4:0] mask_reg;
	logic [4:0] flags_reg;
	logic [4:0] flags_next;
	scc_word_t count_reg;
	scc_word_t count_next;
	scc_word_t stage_reg;
	scc_word_t frame_ts_reg;
	scc_word_t beacon_ts_reg;
	scc_word_t cmp1_reg;
	scc_word_t cmp2_reg;
	scc_word_t cmp3_reg;
	logic busy_reg;
	logic [7:0] presc_reg;
	logic [4:0] backoff_reg;
	logic xtal_prev_reg;
	logic rtc_prev_reg;
	logic [7:0] rdata_reg;
	scc_src_t src;
	logic counter_on;
	logic auto_ts;
	logic xtal_edge;
	logic rtc_edge;
	logic sym_tick;
	logic resync;
	logic backoff_evt;
	logic wrap_evt;
	logic [2:0] match_evt;
	logic [1:0] byte_idx;
	logic [15:0] pan_id;
	logic pan_ok;

	assign counter_on = ctrl0_reg[`SCC_C0_ON];
	assign auto_ts = ctrl0_reg[`SCC_C0_AUTOTS];
	assign pan_id = {pan_identifier_high_i, pan_identifier_low_i};
	assign byte_idx = addr_i[1:0] - 2'(`SCC_CNT_OFF);

	// ----------------------------------------
	// Clock source and symbol tick
	// ----------------------------------------

	// Sleep overrides the selected source without touching the select bit.
	always_comb
	begin
		if (trx_sleep_i || ctrl0_reg[`SCC_C0_RTC])
		begin
			src = SCC_SRC_RTC;
		end
		else
		begin
			src = SCC_SRC_XTAL;
		end
	end

	// Previous oscillator levels for rising edge detection.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			xtal_prev_reg <= 1'b0;
			rtc_prev_reg <= 1'b0;
		end
		else
		begin
			xtal_prev_reg <= crystal_input_i;
			rtc_prev_reg <= rtc_osc_input_i;
		end
	end

	assign xtal_edge = crystal_input_i && !xtal_prev_reg;
	assign rtc_edge = rtc_osc_input_i && !rtc_prev_reg;

	// Resync only exists on the crystal path; on RTC the phase is not kept.
	assign resync = wr_i && (addr_i == `SCC_CTRL0_OFF) && wdata_i[`SCC_C0_RESYNC]
		&& (src == SCC_SRC_XTAL);

	// Crystal edges divide down to one symbol; each RTC edge is one symbol.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			presc_reg <= 8'h00;
		end
		else if (resync)
		begin
			presc_reg <= 8'h00;
		end
		else if (counter_on && src == SCC_SRC_XTAL && xtal_edge)
		begin
			presc_reg <= presc_reg + 8'h01;
		end
	end

	// One-cycle tick per symbol of the source in use, only while enabled.
	always_comb
	begin
		if (!counter_on)
		begin
			sym_tick = 1'b0;
		end
		else if (src == SCC_SRC_RTC)
		begin
			sym_tick = rtc_edge;
		end
		else
		begin
			sym_tick = xtal_edge && !resync
				&& (presc_reg == 8'(`SCC_XTAL_EDGES - 1));
		end
	end

	// ----------------------------------------
	// Backoff slot counter
	// ----------------------------------------

	// Counts symbols in slots of twenty and flags each slot end.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			backoff_reg <= 5'h00;
		end
		else if (resync || !ctrl1_reg[0])
		begin
			backoff_reg <= 5'h00;
		end
		else if (sym_tick)
		begin
			if (backoff_reg == 5'(`SCC_BACKOFF_SYMS - 1))
			begin
				backoff_reg <= 5'h00;
			end
			else
			begin
				backoff_reg <= backoff_reg + 5'h01;
			end
		end
	end

	assign backoff_evt = sym_tick && ctrl1_reg[0] && !resync
		&& (backoff_reg == 5'(`SCC_BACKOFF_SYMS - 1));

	// ----------------------------------------
	// Symbol counter and write staging
	// ----------------------------------------

	// A pending load replaces the increment at the next symbol tick.
	always_comb
	begin
		if (busy_reg)
		begin
			count_next = stage_reg;
		end
		else
		begin
			count_next = count_reg + 32'h00000001;
		end
	end

	// The counter moves only on symbol ticks.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			count_reg <= 32'h00000000;
		end
		else if (sym_tick)
		begin
			count_reg <= count_next;
		end
	end

	// Upper bytes stage; the lowest byte write commits the staged word.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			stage_reg <= 32'h00000000;
		end
		else if (wr_i && counter_on && in_grp(addr_i, `SCC_CNT_OFF))
		begin
			stage_reg <= set_byte(stage_reg, byte_idx, wdata_i);
		end
	end

	// Busy spans from the lowest byte write to the load.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			busy_reg <= 1'b0;
		end
		else if (wr_i && counter_on && addr_i == `SCC_CNT_OFF)
		begin
			busy_reg <= 1'b1;
		end
		else if (sym_tick)
		begin
			busy_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Timestamps
	// ----------------------------------------

	assign pan_ok = (src_pan_i == pan_id) || (pan_id == `SCC_PAN_ANY);

	// Frame stamp follows the frame start when automatic stamping is on.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			frame_ts_reg <= 32'h00000000;
		end
		else if (sfd_i && auto_ts)
		begin
			frame_ts_reg <= count_reg;
		end
	end

	// Manual capture takes priority over a beacon in the same cycle.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			beacon_ts_reg <= 32'h00000000;
		end
		else if (wr_i && addr_i == `SCC_CTRL0_OFF && wdata_i[`SCC_C0_MANUAL])
		begin
			beacon_ts_reg <= count_reg;
		end
		else if (auto_ts && beacon_valid_i && pan_ok)
		begin
			beacon_ts_reg <= frame_ts_reg;
		end
	end

	// ----------------------------------------
	// Events
	// ----------------------------------------

	// Compares look at the value the counter is about to take.
	assign match_evt[0] = sym_tick
		&& count_next == target(ctrl0_reg[0], beacon_ts_reg, cmp1_reg);
	assign match_evt[1] = sym_tick
		&& count_next == target(ctrl0_reg[1], beacon_ts_reg, cmp2_reg);
	assign match_evt[2] = sym_tick
		&& count_next == target(ctrl0_reg[2], beacon_ts_reg, cmp3_reg);
	assign wrap_evt = sym_tick && !busy_reg && (count_reg == 32'hffffffff);

	// ----------------------------------------
	// Status flags and requests
	// ----------------------------------------

	// Events set flags regardless of mask; a set beats a clear.
	always_comb
	begin
		flags_next = flags_reg & ~irq_ack_i;
		if (wr_i && addr_i == `SCC_FLAGS_OFF)
		begin
			flags_next = flags_next & ~wdata_i[4:0];
		end
		flags_next = flags_next | {backoff_evt, wrap_evt, match_evt};
	end

	// Flag register.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			flags_reg <= `SCC_FLAGS_RST;
		end
		else
		begin
			flags_reg <= flags_next;
		end
	end

	// Requests follow flags and masks at once, so a late mask fires now.
	assign backoff_irq_o = flags_reg[`SCC_FL_BACKOFF] && mask_reg[4];
	assign wrap_irq_o = flags_reg[`SCC_FL_WRAP] && mask_reg[3];
	assign match3_irq_o = flags_reg[2] && mask_reg[2];
	assign match2_irq_o = flags_reg[1] && mask_reg[1];
	assign match1_irq_o = flags_reg[0] && mask_reg[0];

	// ----------------------------------------
	// Control and compare registers
	// ----------------------------------------

	// Resync and manual capture are strobes and are never stored.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			ctrl0_reg <= 6'(`SCC_CTRL0_RST);
			ctrl1_reg <= `SCC_CTRL1_RST;
			mask_reg <= `SCC_MASK_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == `SCC_CTRL0_OFF)
			begin
				ctrl0_reg <= wdata_i[5:0];
			end
			if (addr_i == `SCC_CTRL1_OFF)
			begin
				ctrl1_reg <= wdata_i[4:0];
			end
			if (addr_i == `SCC_MASK_OFF)
			begin
				mask_reg <= wdata_i[4:0];
			end
		end
	end

	// Compare values are plain byte-wide read/write storage.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			cmp1_reg <= 32'h00000000;
			cmp2_reg <= 32'h00000000;
			cmp3_reg <= 32'h00000000;
		end
		else if (wr_i)
		begin
			if (in_grp(addr_i, `SCC_CMP1_OFF))
			begin
				cmp1_reg <= set_byte(cmp1_reg, addr_i[1:0], wdata_i);
			end
			if (in_grp(addr_i, `SCC_CMP2_OFF))
			begin
				cmp2_reg <= set_byte(cmp2_reg, addr_i[1:0], wdata_i);
			end
			if (in_grp(addr_i, `SCC_CMP3_OFF))
			begin
				cmp3_reg <= set_byte(cmp3_reg, addr_i[1:0], wdata_i);
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------

	// Read data is registered; unmapped and reserved bits read zero.
	always_ff @(posedge mclk_i)
	begin
		if (!reset_n_i)
		begin
			rdata_reg <= 8'h00;
		end
		else if (rd_i)
		begin
			if (addr_i == `SCC_CTRL0_OFF)
			begin
				rdata_reg <= {2'h0, ctrl0_reg};
			end
			else if (addr_i == `SCC_CTRL1_OFF)
			begin
				rdata_reg <= {3'h0, ctrl1_reg};
			end
			else if (addr_i == `SCC_STATE_OFF)
			begin
				rdata_reg <= {7'h00, busy_reg};
			end
			else if (addr_i == `SCC_MASK_OFF)
			begin
				rdata_reg <= {3'h0, mask_reg};
			end
			else if (addr_i == `SCC_FLAGS_OFF)
			begin
				rdata_reg <= {3'h0, flags_reg};
			end
			else if (in_grp(addr_i, `SCC_CNT_OFF))
			begin
				rdata_reg <= get_byte(count_reg, byte_idx);
			end
			else if (in_grp(addr_i, `SCC_FTS_OFF))
			begin
				rdata_reg <= get_byte(frame_ts_reg, addr_i[1:0] - 2'h1);
			end
			else if (in_grp(addr_i, `SCC_BTS_OFF))
			begin
				rdata_reg <= get_byte(beacon_ts_reg, addr_i[1:0]);
			end
			else if (in_grp(addr_i, `SCC_CMP1_OFF))
			begin
				rdata_reg <= get_byte(cmp1_reg, addr_i[1:0]);
			end
			else if (in_grp(addr_i, `SCC_CMP2_OFF))
			begin
				rdata_reg <= get_byte(cmp2_reg, addr_i[1:0]);
			end
			else if (in_grp(addr_i, `SCC_CMP3_OFF))
			begin
				rdata_reg <= get_byte(cmp3_reg, addr_i[1:0]);
			end
			else
			begin
				rdata_reg <= 8'h00;
			end
		end
		else
		begin
			rdata_reg <= 8'h00;
		end
	end

	assign rdata_o = rdata_reg;

endmodule // scc_ctrl

// [logic/scc_map.svh]
// Register offsets, field positions, reset values and timing counts of the
// symbol counter control block.
// Assumes an 8-bit byte address space on a plain strobe port.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCC_CTRL0_OFF 8'hdc
`define SCC_CTRL1_OFF 8'hdd
`define SCC_STATE_OFF 8'hde
`define SCC_MASK_OFF 8'hdf
`define SCC_FLAGS_OFF 8'he0
`define SCC_CNT_OFF 8'he1
`define SCC_FTS_OFF 8'he9
`define SCC_BTS_OFF 8'hf0
`define SCC_CMP1_OFF 8'hf4
`define SCC_CMP2_OFF 8'hf8
`define SCC_CMP3_OFF 8'hfc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCC_C0_RESYNC 7
`define SCC_C0_MANUAL 6
`define SCC_C0_ON 5
`define SCC_C0_RTC 4
`define SCC_C0_AUTOTS 3
`define SCC_FL_BACKOFF 4
`define SCC_FL_WRAP 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCC_CTRL0_RST 8'h00
`define SCC_CTRL1_RST 5'h00
`define SCC_MASK_RST 5'h00
`define SCC_FLAGS_RST 5'h00
`define SCC_PAN_ANY 16'hffff

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCC_XTAL_MHZ 16
`define SCC_SYMBOL_US 16
`define SCC_XTAL_EDGES (`SCC_XTAL_MHZ * `SCC_SYMBOL_US)
`define SCC_BACKOFF_SYMS 20

`endif

// [logic/scc_pkg.sv]
// Types shared by the symbol counter control block.
// Assumes the map header for all numeric constants.
package scc_pkg;

	// Counter clock source in use.
	typedef enum logic [0:0]
	{
		SCC_SRC_XTAL = 1'b0,
		SCC_SRC_RTC = 1'b1
	} scc_src_t;

	typedef logic [31:0] scc_word_t;

endpackage

// [tb/scc_ctrl_checker.sv]
// Port-level assertions for the symbol counter control block.
// Assumes the map header and one clock domain with a synchronous reset.
`timescale 1ns/10ps
`include "scc_map.svh"

module scc_ctrl_checker
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [4:0] irq_ack_i,
	input wire logic backoff_irq_o,
	input wire logic wrap_irq_o,
	input wire logic match3_irq_o,
	input wire logic match2_irq_o,
	input wire logic match1_irq_o
);
	// -----------------------------------------
	// Request vector and timing defaults
	// -----------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	logic [4:0] irq;

	// Requests gathered in mask bit order.
	assign irq = {backoff_irq_o, wrap_irq_o, match3_irq_o, match2_irq_o, match1_irq_o};

	a_irq_reset_idle: assert property ($rose(reset_n_i) |-> irq == 5'h00)
		else $error("request high right after reset");
	a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data without a read");
	a_unmapped_zero: assert property (rd_i && addr_i == 8'he5 |=> rdata_o == 8'h00)
		else $error("unmapped address read nonzero");
	a_state_reserved: assert property (rd_i && addr_i == `SCC_STATE_OFF |=> rdata_o[7:1] == 7'h00)
		else $error("state reserved bits nonzero");
	a_strobe_self_clear: assert property (rd_i && addr_i == `SCC_CTRL0_OFF |=> rdata_o[7:6] == 2'h0)
		else $error("control strobe bits read back set");
	a_mask_gates_irq: assert property (wr_i && addr_i == `SCC_MASK_OFF |=> ({3'h0, irq} & ~$past(wdata_i)) == 8'h00)
		else $error("request without its mask bit");
	a_flag_write_clear: assert property (wr_i && addr_i == `SCC_FLAGS_OFF |=> ({3'h0, irq} & $past(wdata_i)) == 8'h00)
		else $error("write one did not clear request");
	a_ack_clears_irq: assert property (irq_ack_i != 5'h00 |=> (irq & $past(irq_ack_i)) == 5'h00)
		else $error("service did not clear request");
	a_irq_fall_cause: assert property ($past(reset_n_i) && (|($past(irq) & ~irq)) |-> $past(wr_i) || (|$past(irq_ack_i)))
		else $error("request dropped without cause");
endmodule // scc_ctrl_checker

bind scc_ctrl scc_ctrl_checker u_scc_ctrl_checker (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.irq_ack_i(irq_ack_i), .backoff_irq_o(backoff_irq_o), .wrap_irq_o(wrap_irq_o),
	.match3_irq_o(match3_irq_o), .match2_irq_o(match2_irq_o), .match1_irq_o(match1_irq_o));

// [tb/scc_radio_model.sv]
// Oscillators and transceiver frame events facing the symbol counter.
// Assumes its tasks are called from the bench, one at a time.
`timescale 1ns/10ps

module scc_radio_model
(
	input wire logic mclk_i,
	output logic crystal_o,
	output logic rtc_o,
	output logic sfd_o,
	output logic beacon_valid_o,
	output logic [15:0] src_pan_o
);
	logic [1:0] div_reg = 2'h0;

	// Crystal runs free, one rising edge every four system cycles.
	always @(posedge mclk_i)
		div_reg <= div_reg + 2'h1;
	assign crystal_o = div_reg[1];

	// Idle levels at start.
	initial
	begin
		rtc_o = 1'b0;
		sfd_o = 1'b0;
		beacon_valid_o = 1'b0;
		src_pan_o = 16'h0000;
	end

	// Bursts of slow oscillator edges; the line rests low between bursts.
	task automatic rtc_ticks(input int n);
		repeat (n)
		begin
			@(posedge mclk_i);
			rtc_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			rtc_o <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
	endtask

	// Frame start, then a valid beacon carrying its source network id.
	task automatic frame(input logic [15:0] pan);
		@(posedge mclk_i);
		sfd_o <= 1'b1;
		@(posedge mclk_i);
		sfd_o <= 1'b0;
		src_pan_o <= pan;
		beacon_valid_o <= 1'b1;
		@(posedge mclk_i);
		beacon_valid_o <= 1'b0;
		src_pan_o <= ~pan;
		repeat (2) @(posedge mclk_i);
	endtask
endmodule // scc_radio_model

// [tb/symbol_counter_ctrl_irq_bench.sv]
// Self-checking bench for the symbol counter control block.
// Assumes the map header, the radio model and a 100 MHz system clock.
`timescale 1ns/10ps
`include "scc_map.svh"

module symbol_counter_ctrl_irq_bench
	import scc_pkg::*;
;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic trx_sleep_i = 1'b0;
	logic [15:0] pan_id = 16'h1234;
	logic [4:0] irq_ack_i = 5'h00;
	logic [7:0] rdata_o;
	logic crystal, rtc, sfd, bvalid;
	logic [15:0] src_pan;
	logic [4:0] irq_v;
	scc_word_t c0;
	int n_errors = 0;
	int n_checks = 0;

	// System clock.
	always #5 mclk_i = ~mclk_i;

	scc_ctrl u_scc_ctrl (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.crystal_input_i(crystal), .rtc_osc_input_i(rtc), .trx_sleep_i(trx_sleep_i),
		.sfd_i(sfd), .beacon_valid_i(bvalid), .src_pan_i(src_pan),
		.pan_identifier_high_i(pan_id[15:8]), .pan_identifier_low_i(pan_id[7:0]),
		.irq_ack_i(irq_ack_i), .backoff_irq_o(irq_v[4]), .wrap_irq_o(irq_v[3]),
		.match3_irq_o(irq_v[2]), .match2_irq_o(irq_v[1]), .match1_irq_o(irq_v[0]));

	scc_radio_model u_scc_radio_model (.mclk_i(mclk_i), .crystal_o(crystal), .rtc_o(rtc),
		.sfd_o(sfd), .beacon_valid_o(bvalid), .src_pan_o(src_pan));

	// -----------------------------------------
	// Bus and comparison tasks
	// -----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] b;
		rd(a, b);
		check(32'(b), 32'(e));
	endtask

	task automatic get32(input logic [7:0] base, output scc_word_t v);
		for (int i = 0; i < 4; i++)
			rd(base + 8'(i), v[8*i +: 8]);
	endtask

	task automatic chk32(input logic [7:0] base, input scc_word_t e);
		scc_word_t v;
		get32(base, v);
		check(v, e);
	endtask

	task automatic irq_chk(input logic [4:0] e);
		#1 check(32'(irq_v), 32'(e));
	endtask

	task automatic ticks(input int n);
		u_scc_radio_model.rtc_ticks(n);
		repeat (3) @(posedge mclk_i);
	endtask

	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cuts a hang short after far longer than the sequence needs.
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		stop_test();
	end

	// -----------------------------------------
	// Test sequence
	// -----------------------------------------
	initial
	begin
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd_chk(`SCC_MASK_OFF, 8'h00);
		rd_chk(`SCC_FLAGS_OFF, 8'h00);
		rd_chk(`SCC_CTRL1_OFF, 8'h00);
		rd_chk(8'he5, 8'h00);
		wr(`SCC_CTRL0_OFF, 8'h10);
		wr(`SCC_CNT_OFF, 8'h55);
		rd_chk(`SCC_STATE_OFF, 8'h00);
		ticks(2);
		chk32(`SCC_CNT_OFF, 32'h00000000);
		wr(`SCC_CTRL0_OFF, 8'h30);
		ticks(3);
		chk32(`SCC_CNT_OFF, 32'h00000003);
		for (int i = 3; i >= 0; i--)
			wr(`SCC_CNT_OFF + 8'(i), (i == 0) ? 8'hfe : 8'hff);
		rd_chk(`SCC_STATE_OFF, 8'h01);
		ticks(1);
		rd_chk(`SCC_STATE_OFF, 8'h00);
		chk32(`SCC_CNT_OFF, 32'hfffffffe);
		ticks(2);
		rd_chk(`SCC_FLAGS_OFF, 8'h0f);
		irq_chk(5'h00);
		wr(`SCC_MASK_OFF, 8'h08);
		irq_chk(5'h08);
		@(posedge mclk_i);
		irq_ack_i <= 5'h08;
		@(posedge mclk_i);
		irq_ack_i <= 5'h00;
		irq_chk(5'h00);
		rd_chk(`SCC_FLAGS_OFF, 8'h07);
		wr(`SCC_FLAGS_OFF, 8'h07);
		wr(`SCC_MASK_OFF, 8'h01);
		ticks(5);
		wr(`SCC_CTRL0_OFF, 8'h70);
		chk32(`SCC_BTS_OFF, 32'h00000005);
		rd_chk(`SCC_CTRL0_OFF, 8'h30);
		wr(`SCC_CMP1_OFF, 8'h07);
		wr(`SCC_CMP2_OFF, 8'h04);
		wr(`SCC_CMP3_OFF, 8'h03);
		wr(`SCC_CTRL0_OFF, 8'h36);
		ticks(1);
		rd_chk(`SCC_FLAGS_OFF, 8'h00);
		ticks(1);
		rd_chk(`SCC_FLAGS_OFF, 8'h01);
		irq_chk(5'h01);
		ticks(1);
		rd_chk(`SCC_FLAGS_OFF, 8'h05);
		ticks(1);
		rd_chk(`SCC_FLAGS_OFF, 8'h07);
		irq_chk(5'h01);
		wr(`SCC_FLAGS_OFF, 8'h07);
		rd_chk(`SCC_FLAGS_OFF, 8'h00);
		wr(`SCC_MASK_OFF, 8'h00);
		u_scc_radio_model.frame(16'h1234);
		chk32(`SCC_FTS_OFF, 32'h00000000);
		chk32(`SCC_BTS_OFF, 32'h00000005);
		wr(`SCC_CTRL0_OFF, 8'h3e);
		ticks(1);
		u_scc_radio_model.frame(16'h4321);
		chk32(`SCC_FTS_OFF, 32'h0000000a);
		chk32(`SCC_BTS_OFF, 32'h00000005);
		u_scc_radio_model.frame(16'h1234);
		chk32(`SCC_BTS_OFF, 32'h0000000a);
		@(posedge mclk_i);
		pan_id <= 16'hffff;
		ticks(1);
		u_scc_radio_model.frame(16'h5555);
		chk32(`SCC_BTS_OFF, 32'h0000000b);
		wr(`SCC_CTRL1_OFF, 8'h01);
		wr(`SCC_FLAGS_OFF, 8'h10);
		wr(`SCC_MASK_OFF, 8'h10);
		ticks(19);
		irq_chk(5'h00);
		ticks(1);
		irq_chk(5'h10);
		rd_chk(`SCC_CTRL1_OFF, 8'h01);
		wr(`SCC_FLAGS_OFF, 8'h1f);
		irq_chk(5'h00);
		wr(`SCC_CTRL1_OFF, 8'h00);
		wr(`SCC_CTRL0_OFF, 8'h20);
		repeat (300) @(posedge mclk_i);
		wr(`SCC_CTRL0_OFF, 8'ha0);
		rd_chk(`SCC_CTRL0_OFF, 8'h20);
		get32(`SCC_CNT_OFF, c0);
		repeat (880) @(posedge mclk_i);
		chk32(`SCC_CNT_OFF, c0);
		repeat (200) @(posedge mclk_i);
		chk32(`SCC_CNT_OFF, c0 + 32'h1);
		@(posedge mclk_i);
		trx_sleep_i <= 1'b1;
		ticks(3);
		chk32(`SCC_CNT_OFF, c0 + 32'h4);
		@(posedge mclk_i);
		trx_sleep_i <= 1'b0;
		ticks(2);
		chk32(`SCC_CNT_OFF, c0 + 32'h4);
		stop_test();
	end
endmodule // symbol_counter_ctrl_irq_bench
